// [include/str_cmd_pkg.sv]
/*
  constants for the setup-mode string command handler.
  assumes a 50 MHz core clock and byte-wide host receive data.
*/
package str_cmd_pkg;
  localparam int          CLK_HZ        = 50_000_000;
  localparam logic [7:0]  CH_OPEN       = 8'h5b;
  localparam logic [7:0]  CH_CLOSE      = 8'h5d;
  localparam logic [7:0]  CH_CR         = 8'h0d;
  localparam logic [7:0]  CH_DOLLAR     = 8'h24;
  localparam logic [7:0]  CH_COLON      = 8'h3a;
  localparam int          AUX_MAX       = 30;
  localparam int          PKT_MAX       = 16;
  localparam int          AUX_BAUD      = 4800;
  localparam int          AUX_BIT_CYC   = CLK_HZ / AUX_BAUD;
  localparam int          ACK_MS        = 20;
  localparam int          ACK_CYC       = CLK_HZ / 1000 * ACK_MS;
  localparam logic [4:0]  FIFO_DEPTH    = 5'h10;
  localparam logic [4:0]  FIFO_3Q       = 5'h0c;
  typedef enum logic [2:0] {ST_IDLE, ST_AUX, ST_LEN, ST_DATA, ST_SEND} mode_e;
endpackage

// [rtl/str_cmd.sv]
/*
  setup-mode string command handler: aux strings, '$' packet transmit,
  transparent stream buffer and acknowledge burst timer.
  assumes host bytes arrive as a one-cycle strobe from a receiver on core_clk.
*/
// What this block does
// (R01) an opening bracket starts an aux string whose bytes go to the aux output until a closing bracket.
// (R02) aux strings hold 0 to 30 bytes, and ending one with CR appends a CR byte to the output.
// (R03) a dollar byte in setup mode starts a one-packet transmit without leaving command mode.
// (R04) the hex length character sets the packet length to its value plus one, 1 to 16 bytes.
// (R05) a colon is echoed to the host after the length character.
// (R06) after the last data byte the transmitter is keyed, the packet sent, and setup mode resumes.
// (R07) transparent streaming at 4800 baud drains into the radio path without buffer overflow.
// (R08) an acknowledge burst keys the transmitter for 20 ms.
// (R09) the host should obey the buffer-level flag as clear-to-send in acknowledge mode.
// (R10) the buffer level flag rises at three quarters full and falls only when empty.
// (R11) aux bytes leave as 8N1 serial at the aux baud rate in order received.
`timescale 1ns/10ps
module str_cmd
  import str_cmd_pkg::*;
#(
  parameter int ACK_CYCLES = ACK_CYC
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // host receive side
  input  wire logic       setup_mode,
  input  wire logic       host_valid,
  input  wire logic [7:0] host_byte,
  input  wire logic       ack_req,
  // echo to host
  output logic            echo_valid,
  output logic [7:0]      echo_byte,
  // radio side
  input  wire logic       radio_ready,
  output logic            tx_key,
  output logic            radio_valid,
  output logic [7:0]      radio_byte,
  output logic            tx_level,
  // aux serial pin
  output logic            aux_txd
);
  import str_cmd_pkg::*;

  typedef struct packed {
    mode_e                  mode;
    logic [4:0]             cnt;
    logic [4:0]             len;
    logic [PKT_MAX*8-1:0]   fifo;
    logic [4:0]             fill;
    logic                   level;
    logic                   echo_v;
    logic [7:0]             echo_b;
    logic                   rad_v;
    logic [7:0]             rad_b;
    logic                   key;
    logic [PKT_MAX*8-1:0]   pkt;
    logic [4:0]             sidx;
    logic [AUX_MAX*8+7:0]   aq;
    logic [5:0]             aq_n;
    logic [9:0]             sh;
    logic [3:0]             bits;
    logic [15:0]            baud;
    logic                   txd;
    logic [31:0]            ack;
    logic                   txk;
  } state_s;

  state_s q, d;
  logic   hv_ok;

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return 5'(c - 8'h30);
    if (c >= 8'h41 && c <= 8'h46) return 5'(c - 8'h37);
    if (c >= 8'h61 && c <= 8'h66) return 5'(c - 8'h57);
    return 5'h1f;
  endfunction

  assign hv_ok = hex_val(host_byte) != 5'h1f;

  always_comb begin
    logic [4:0] hv;
    hv = hex_val(host_byte);
    d = q;
    d.echo_v = 1'b0;
    d.rad_v = 1'b0;
    // serialiser: one byte at a time, start/8 data lsb first/stop
    if (q.bits != 4'h0) begin
      if (q.baud == 16'(AUX_BIT_CYC - 1)) begin
        d.baud = 16'h0000;
        d.txd  = q.sh[0];                                    // [R11]
        d.sh   = {1'b1, q.sh[9:1]};
        d.bits = q.bits - 4'h1;
      end else begin
        d.baud = q.baud + 16'h0001;
      end
    end else if (q.aq_n != 6'h00) begin
      d.sh   = {1'b1, q.aq[7:0], 1'b0};                      // [R11]
      // eleventh shift holds the stop bit a full bit time before the next start
      d.bits = 4'hb;
      d.baud = 16'(AUX_BIT_CYC - 1);
      d.aq   = {8'h00, q.aq[AUX_MAX*8+7:8]};
      d.aq_n = q.aq_n - 6'h01;
    end
    case (q.mode)
      ST_IDLE: begin
        if (host_valid && setup_mode) begin
          if (host_byte == CH_OPEN) begin
            d.mode = ST_AUX;                                 // [R01]
            d.cnt  = 5'h00;
          end else if (host_byte == CH_DOLLAR) begin
            d.mode = ST_LEN;                                 // [R03]
          end
        end else if (host_valid && q.fill != FIFO_DEPTH) begin
          // transparent stream into the radio buffer
          d.fifo = q.fifo | ((PKT_MAX*8)'(host_byte) << (q.fill * 8)); // [R07]
          d.fill = q.fill + 5'h01;
        end
      end
      ST_AUX: begin
        if (host_valid) begin
          if (host_byte == CH_CLOSE) begin
            d.mode = ST_IDLE;                                // [R01]
          end else if (host_byte == CH_CR) begin
            // append after whatever the serialiser took this cycle; a full queue drops
            if (d.aq_n != 6'(AUX_MAX + 1)) begin
              d.aq[d.aq_n*8 +: 8] = CH_CR;                   // [R02]
              d.aq_n = d.aq_n + 6'h01;
            end
            d.mode = ST_IDLE;
          end else if (q.cnt != 5'(AUX_MAX) && d.aq_n != 6'(AUX_MAX + 1)) begin
            d.aq[d.aq_n*8 +: 8] = host_byte;                 // [R01]
            d.aq_n = d.aq_n + 6'h01;
            d.cnt  = q.cnt + 5'h01;                          // [R02]
          end
        end
      end
      ST_LEN: begin
        if (host_valid) begin
          if (hv == 5'h1f) begin
            d.mode = ST_IDLE;
          end else begin
            d.len    = hv;                                   // [R04]
            d.cnt    = 5'h00;
            d.echo_v = 1'b1;                                 // [R05]
            d.echo_b = CH_COLON;
            d.mode   = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (host_valid) begin
          d.pkt[q.cnt*8 +: 8] = host_byte;                   // [R04]
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == q.len) begin
            d.mode = ST_SEND;                                // [R06]
            d.sidx = 5'h00;
            d.key  = 1'b1;
          end
        end
      end
      ST_SEND: begin
        if (radio_ready) begin
          d.rad_v = 1'b1;                                    // [R06]
          d.rad_b = q.pkt[q.sidx*8 +: 8];
          d.sidx  = q.sidx + 5'h01;
          if (q.sidx == q.len) begin
            d.key  = 1'b0;
            d.mode = ST_IDLE;
          end
        end
      end
      default: d.mode = ST_IDLE;
    endcase
    // stream drain when the packet path is idle
    if (q.mode == ST_IDLE && !d.rad_v && radio_ready && q.fill != 5'h00 &&
        !(host_valid && !setup_mode)) begin
      d.rad_v = 1'b1;                                        // [R07]
      d.rad_b = q.fifo[7:0];
      d.fifo  = {8'h00, q.fifo[PKT_MAX*8-1:8]};
      d.fill  = q.fill - 5'h01;
    end
    if (d.fill >= FIFO_3Q) d.level = 1'b1;                   // [R10]
    else if (d.fill == 5'h00) d.level = 1'b0;
    // acknowledge burst timer
    if (q.ack != 32'h0) d.ack = q.ack - 32'h1;
    else if (ack_req) d.ack = 32'(ACK_CYCLES);               // [R08]
    // key is registered so the pin never glitches between packet and burst
    d.txk = d.key | (d.ack != 32'h0);                        // [R06] [R08]
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.txd <= 1'b1;
      q.mode <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign echo_valid  = q.echo_v;
  assign echo_byte   = q.echo_b;
  assign tx_key      = q.txk;
  assign radio_valid = q.rad_v;
  assign radio_byte  = q.rad_b;
  assign tx_level    = q.level;                              // [R09]
  assign aux_txd     = q.txd;

  aux_cap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    q.aq_n <= 6'(AUX_MAX + 1)) else $error("aux queue overrun"); // [R02]
  colon_echo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q.mode == ST_LEN && host_valid && hv_ok) |=> echo_valid && echo_byte == CH_COLON)
    else $error("no colon after length"); // [R05]
  dollar_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q.mode == ST_IDLE && setup_mode && host_valid && host_byte == CH_DOLLAR)
    |=> q.mode == ST_LEN) else $error("dollar ignored"); // [R03]
  sequence last_byte_s;
    q.mode == ST_DATA && host_valid && q.cnt == q.len;
  endsequence
  key_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    last_byte_s |=> tx_key && q.mode == ST_SEND) else $error("no key"); // [R06]
  len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    q.len < 5'(PKT_MAX)) else $error("length too big"); // [R04]
  level_hi_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    q.fill >= FIFO_3Q |-> tx_level) else $error("level low at 3/4"); // [R10]
  level_lo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(tx_level) |-> q.fill == 5'h00) else $error("level fell early"); // [R10]
  open_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q.mode == ST_IDLE && setup_mode && host_valid && host_byte == CH_OPEN)
    |=> q.mode == ST_AUX) else $error("bracket ignored"); // [R01]
  ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q.ack == 32'h0 && ack_req) |=> tx_key [*8]) else $error("ack burst short"); // [R08]
  fifo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    q.fill <= FIFO_DEPTH) else $error("buffer overflow"); // [R07]
  serial_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q.bits == 4'h0) |-> aux_txd) else $error("aux line not idle"); // [R11]
endmodule

// [dv/radio_model.sv]
/*
  behavioural radio that takes packet and stream bytes from the handler.
  assumes the handler pulses radio_valid only the cycle after it sees radio_ready high.
*/
`timescale 1ns/10ps
module radio_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // pace: 0 always ready, 1 every other cycle, 2 stalled
  input  wire logic [1:0] pace,
  // handler side
  input  wire logic       radio_valid,
  input  wire logic [7:0] radio_byte,
  output logic            radio_ready
);
  logic [7:0] got[$];
  logic       tog_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_q       <= 1'b0;
      radio_ready <= 1'b0;
    end else begin
      tog_q       <= ~tog_q;
      radio_ready <= (pace == 2'h0) || (pace == 2'h1 && tog_q);
      if (radio_valid === 1'b1) got.push_back(radio_byte);
    end
  end
endmodule

// [dv/tb.sv]
/*
  self-checking bench for the string command handler.
  assumes radio_model on the radio side; the bench plays the host.
*/
`timescale 1ns/10ps
module tb;
  import str_cmd_pkg::*;
  logic       core_clk, rst_n, setup_mode, host_valid, ack_req, echo_valid;
  logic       radio_ready, tx_key, radio_valid, tx_level, aux_txd, key_q;
  logic [7:0] host_byte, echo_byte, radio_byte, last_echo;
  logic [1:0] pace;
  int         n_errors, total_checks, n_echo, n_key, e0, k0, cnt;
  str_cmd #(.ACK_CYCLES(20)) str_cmd_i (.core_clk(core_clk), .rst_n(rst_n),
    .setup_mode(setup_mode), .host_valid(host_valid), .host_byte(host_byte),
    .ack_req(ack_req), .echo_valid(echo_valid), .echo_byte(echo_byte),
    .radio_ready(radio_ready), .tx_key(tx_key), .radio_valid(radio_valid),
    .radio_byte(radio_byte), .tx_level(tx_level), .aux_txd(aux_txd));
  radio_model radio_model_i (.core_clk(core_clk), .rst_n(rst_n), .pace(pace),
    .radio_valid(radio_valid), .radio_byte(radio_byte), .radio_ready(radio_ready));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // pulse counters sample before the edge's own updates land
  always @(posedge core_clk) begin
    if (echo_valid === 1'b1) begin
      n_echo++;
      last_echo = echo_byte;
    end
    if (tx_key === 1'b1 && key_q !== 1'b1) n_key++;
    key_q = tx_key;
  end
  task end_sim();
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // small delay so this edge's register updates are visible
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    #1;
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task send(input logic [7:0] b);
    @(posedge core_clk);
    host_valid <= 1'b1;
    host_byte  <= b;
    @(posedge core_clk);
    host_valid <= 1'b0;
  endtask
  // looks 1 ns after each edge so the edge's own register updates are seen
  task wait_for(input int sel, input logic v);
    cnt = 0;
    #1;
    while ((sel == 0 ? tx_key : sel == 1 ? tx_level : aux_txd) !== v) begin
      @(posedge core_clk);
      #1;
      cnt++;
      if (cnt > 30000) begin
        chk(1'b0, 1'b1);
        end_sim();
      end
    end
  endtask
  task pkt(input logic [7:0] lc, input int n, input logic [1:0] sp);
    pace <= sp;
    radio_model_i.got.delete();
    e0 = n_echo;
    k0 = n_key;
    send(CH_DOLLAR);
    send(lc);
    repeat (2) @(posedge core_clk);
    chk(n_echo, e0 + 1);
    chk(last_echo, CH_COLON);
    for (int i = 0; i < n; i++) begin
      if (i == n - 1) chk(tx_key, 1'b0);
      send(8'h40 + i[7:0]);
    end
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    repeat (2) @(posedge core_clk);
    chk(n_key, k0 + 1);
    chk(radio_model_i.got.size(), n);
    for (int i = 0; i < n; i++) chk(radio_model_i.got[i], 8'h40 + i[7:0]);
    chk(aux_txd, 1'b1);
  endtask
  task abort_len();
    e0 = n_echo;
    k0 = n_key;
    send(8'h41);
    send(CH_DOLLAR);
    send(8'h47);
    send(8'h35);
    repeat (4) @(posedge core_clk);
    chk(n_echo, e0);
    chk(n_key, k0);
  endtask
  task stream();
    @(posedge core_clk);
    setup_mode <= 1'b0;
    pace       <= 2'h2;
    radio_model_i.got.delete();
    for (int i = 0; i < 17; i++) begin
      if (i > 10) begin
        repeat (2) @(posedge core_clk);
        chk(tx_level, i > 11);
      end
      send(8'h60 + i[7:0]);
    end
    pace <= 2'h0;
    repeat (3) @(posedge core_clk);
    chk(tx_level, 1'b1);
    wait_for(1, 1'b0); // host holds off until clear-to-send
    repeat (3) @(posedge core_clk);
    chk(radio_model_i.got.size(), 16);
    chk(radio_model_i.got[15], 8'h6f);
    @(posedge core_clk);
    setup_mode <= 1'b1;
  endtask
  task ack_burst();
    @(posedge core_clk);
    ack_req <= 1'b1;
    @(posedge core_clk);
    ack_req <= 1'b0;
    wait_for(0, 1'b1);
    cnt = 0;
    while (tx_key === 1'b1 && cnt < 100) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    chk(cnt, 20);
  endtask
  // full byte takes 10 bit times at 4800 baud; only the first two data bits are judged
  task aux_str();
    send(CH_OPEN);
    send(8'h41);
    send(CH_CR);
    wait_for(2, 1'b0);
    repeat (AUX_BIT_CYC * 3 / 2) @(posedge core_clk);
    chk(aux_txd, 1'b1);
    repeat (AUX_BIT_CYC) @(posedge core_clk);
    chk(aux_txd, 1'b0);
  endtask
  initial begin
    rst_n      = 1'b0;
    setup_mode = 1'b1;
    host_valid = 1'b0;
    host_byte  = 8'h00;
    ack_req    = 1'b0;
    pace       = 2'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    chk(aux_txd, 1'b1);
    pkt(8'h30, 1, 2'h0);
    pkt(8'h46, 16, 2'h1);
    pkt(8'h39, 10, 2'h0);
    abort_len();
    // empty bracket pair must close cleanly, forward nothing, and free the dollar command
    send(CH_OPEN);
    send(CH_CLOSE);
    pkt(8'h61, 11, 2'h0);
    stream();
    ack_burst();
    aux_str();
    end_sim();
  end
endmodule
